// File: core/adcfs_top.sv
// top: result formatting, channel coding, sequence status flags and counter, AXI4-Lite slave
module adcfs_top (
  input  wire logic                        clk_in,          // 20 MHz clock
  input  wire logic                        rst_b_in,        // async reset, active low
  input  wire logic                        ce_in,           // clock enable, freezes state
  input  wire logic                        special_mode_in, // special mode, unlocks test reg
  input  wire logic                        ext_trig_in,     // external trigger
  input  wire adcfs_pkg::adcfs_conv_t      conv_in,         // conversion result from front end
  output logic [adcfs_pkg::CNT_W-1:0]      channel_out,     // analog input being sampled
  output logic                             busy_out,        // sequence in progress
  input  wire logic [adcfs_pkg::ADDR_W-1:0] s_axi_awaddr_in,  // write address
  input  wire logic                        s_axi_awvalid_in, // write address valid
  output logic                             s_axi_awready_out,// write address ready
  input  wire logic [31:0]                 s_axi_wdata_in,   // write data
  input  wire logic [3:0]                  s_axi_wstrb_in,   // write strobes
  input  wire logic                        s_axi_wvalid_in,  // write data valid
  output logic                             s_axi_wready_out, // write data ready
  output logic [1:0]                       s_axi_bresp_out,  // write response
  output logic                             s_axi_bvalid_out, // write response valid
  input  wire logic                        s_axi_bready_in,  // write response ready
  input  wire logic [adcfs_pkg::ADDR_W-1:0] s_axi_araddr_in,  // read address
  input  wire logic                        s_axi_arvalid_in, // read address valid
  output logic                             s_axi_arready_out,// read address ready
  output logic [31:0]                      s_axi_rdata_out,  // read data
  output logic [1:0]                       s_axi_rresp_out,  // read response
  output logic                             s_axi_rvalid_out, // read data valid
  input  wire logic                        s_axi_rready_in   // read data ready
);
  import adcfs_pkg::*;

  logic                 rst_s1;
  logic                 rst_n;
  logic [ADDR_W-1:0]    aw_addr;
  logic                 aw_full;
  logic [7:0]           w_byte;
  logic                 w_lane;
  logic                 w_full;
  logic [7:0]           ctl2;
  logic [7:0]           ctl3;
  logic [7:0]           ctl4;
  logic [7:0]           ctl5;
  logic [7:0]           test_reg;
  adcfs_state_t         state;
  logic [CNT_W-1:0]     conv_cnt;
  logic [CNT_W-1:0]     seq_pos;
  logic [NRES-1:0]      ccf;
  logic [RAW_W-1:0]     res [NRES];
  logic                 sequence_complete_flag;
  logic                 trigger_overrun_flag;
  logic                 result_overwrite_flag;
  logic                 trig_q;
  logic                 ccf_armed;
  adcfs_fmt_t           fmt;
  logic                 wr_go;
  logic [5:0]           wr_idx;
  logic                 rd_go;
  logic [5:0]           rd_idx;
  logic                 wr_ctl;
  logic                 abort;
  logic                 start_sw;
  logic                 trig_rise;
  logic                 trig_start;
  logic                 conv_take;
  logic                 seq_last;
  logic                 seq_end;
  logic                 res_rd;
  logic [CNT_W-1:0]     rd_sel;
  logic [NRES-1:0]      ccf_set;
  logic [NRES-1:0]      ccf_clr;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // result word layout for the selected format
  function automatic logic [15:0] fmt_word(input logic [RAW_W-1:0] raw, input adcfs_fmt_t f);
    logic [15:0] w;
    w = 16'h0000;
    if (f.low_res && f.rjust) begin
      w = {8'h00, raw[RAW_W-1:2]};
    end else if (f.low_res) begin
      w = {raw[RAW_W-1] ^ f.signd, raw[RAW_W-2:2], 8'h00};
    end else if (f.rjust) begin
      w = {6'h00, raw};
    end else begin
      w = {raw[RAW_W-1] ^ f.signd, raw[RAW_W-2:0], 6'h00};
    end
    return w;
  endfunction

  assign fmt.low_res = ctl4[C4_LOW_RES];
  assign fmt.rjust   = ctl5[C5_RJUST];
  assign fmt.signd   = ctl5[C5_SIGNED];

  // bus side effects
  assign wr_go   = ce_in && aw_full && w_full && !s_axi_bvalid_out;
  assign wr_idx  = aw_addr[7:2];
  assign wr_ctl  = wr_go && w_lane;
  assign rd_go   = ce_in && s_axi_arvalid_in && s_axi_arready_out;
  assign rd_idx  = s_axi_araddr_in[7:2];
  assign res_rd  = rd_go && (rd_idx >= IDX_RES0) && (rd_idx < IDX_RES0 + 6'(NRES));
  assign rd_sel  = rd_idx[CNT_W-1:0];

  // sequence events
  assign abort      = wr_ctl && (wr_idx == IDX_CTL2 || wr_idx == IDX_CTL3 || wr_idx == IDX_CTL4);
  assign start_sw   = wr_ctl && (wr_idx == IDX_CTL5) && !abort;
  assign trig_rise  = ext_trig_in && !trig_q;
  assign trig_start = ce_in && ctl2[C2_TRIG_EN] && state == ADCFS_IDLE && !abort && !start_sw &&
                      (ctl2[C2_TRIG_LVL] ? ext_trig_in : trig_rise);
  assign conv_take  = ce_in && state == ADCFS_RUN && conv_in.done && !abort && !start_sw;
  assign seq_last   = seq_pos == ctl3[C3_LEN_LSB +: CNT_W] - 3'h1;
  assign seq_end    = conv_take && seq_last;

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_full           <= 1'b0;
      aw_addr           <= '0;
      s_axi_awready_out <= 1'b1;
      w_full            <= 1'b0;
      w_byte            <= 8'h00;
      w_lane            <= 1'b0;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OK;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr           <= s_axi_awaddr_in;
        aw_full           <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_byte           <= s_axi_wdata_in[7:0];
        w_lane           <= s_axi_wstrb_in[0];
        w_full           <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (wr_idx inside {IDX_CTL2, IDX_CTL3, IDX_CTL4, IDX_CTL5, IDX_STAT0,
                             IDX_TEST0, IDX_CCF} || (wr_idx >= IDX_RES0 &&
                             wr_idx < IDX_RES0 + 6'(NRES))) ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        aw_full           <= 1'b0;
        w_full            <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= RESP_OK;
    end else if (ce_in) begin
      if (rd_go) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= RESP_OK;
        s_axi_rdata_out   <= 32'h0000_0000;
        if (res_rd) begin
          s_axi_rdata_out <= {16'h0000, fmt_word(res[rd_sel], fmt)};
        end else begin
          case (rd_idx)
            IDX_CTL2:  s_axi_rdata_out <= {24'h000000, ctl2};
            IDX_CTL3:  s_axi_rdata_out <= {24'h000000, ctl3};
            IDX_CTL4:  s_axi_rdata_out <= {24'h000000, ctl4};
            IDX_CTL5:  s_axi_rdata_out <= {24'h000000, ctl5};
            IDX_STAT0: s_axi_rdata_out <= {24'h000000, sequence_complete_flag, 1'b0, trigger_overrun_flag, result_overwrite_flag, 1'b0,
                                           conv_cnt};
            IDX_TEST0: s_axi_rdata_out <= {24'h000000, test_reg};
            IDX_CCF:   s_axi_rdata_out <= {24'h000000, ccf};
            default:   s_axi_rresp_out <= RESP_ERR;
          endcase
        end
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // control registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctl2     <= CTL_RST;
      ctl3     <= CTL_RST;
      ctl4     <= CTL_RST;
      ctl5     <= CTL_RST;
      test_reg <= TEST_RST;
    end else if (wr_ctl) begin
      case (wr_idx)
        IDX_CTL2:  ctl2 <= w_byte;
        IDX_CTL3:  ctl3 <= w_byte;
        IDX_CTL4:  ctl4 <= w_byte;
        IDX_CTL5:  ctl5 <= w_byte;
        IDX_TEST0: if (special_mode_in) test_reg <= w_byte;
        default:   ;
      endcase
    end
  end

  // sequence controller and channel selection
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ADCFS_IDLE;
      seq_pos     <= '0;
      channel_out <= '0;
      busy_out    <= 1'b0;
      trig_q      <= 1'b0;
    end else if (ce_in) begin
      trig_q <= ext_trig_in;
      if (abort) begin
        state    <= ADCFS_IDLE;
        busy_out <= 1'b0;
      end else if (start_sw || trig_start) begin
        state       <= ADCFS_RUN;
        busy_out    <= 1'b1;
        seq_pos     <= '0;
        channel_out <= start_sw ? w_byte[C5_CODE_LSB +: CNT_W]
                                : ctl5[C5_CODE_LSB +: CNT_W];
      end else if (conv_take) begin
        seq_pos     <= seq_last ? '0 : seq_pos + 3'h1;
        channel_out <= (ctl5[C5_MULTI_CHANNEL_SELECT] && !seq_last) ? channel_out + 3'h1
                                                    : ctl5[C5_CODE_LSB +: CNT_W];
        if (seq_last && !ctl5[C5_SCAN]) begin
          state    <= ADCFS_IDLE;
          busy_out <= 1'b0;
        end
      end
    end
  end

  // conversion counter
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt <= '0;
    end else if (ce_in) begin
      if (abort || start_sw) begin
        conv_cnt <= '0;
      end else if (trig_start && !ctl3[C3_FIFO]) begin
        conv_cnt <= '0;
      end else if (conv_take) begin
        conv_cnt <= (seq_last && !ctl3[C3_FIFO]) ? '0 : conv_cnt + 3'h1;
      end
    end
  end

  // result storage
  always_ff @(posedge clk_in) begin
    if (conv_take) begin
      res[conv_cnt] <= conv_in.data;
    end
  end

  // complete flags; a read of the complete flag register arms the clear-by-result-read path
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ccf_armed <= 1'b0;
    end else if (rd_go) begin
      ccf_armed <= (rd_idx == IDX_CCF) || (ccf_armed && !res_rd);
    end
  end

  for (genvar i = 0; i < NRES; i++) begin : g_ccf
    assign ccf_set[i] = conv_take && conv_cnt == 3'(i);
    assign ccf_clr[i] = start_sw || (res_rd && rd_sel == 3'(i) &&
                        (ctl2[C2_FAST_CLR] || ccf_armed));
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        ccf[i] <= 1'b0;
      end else if (ce_in) begin
        ccf[i] <= ccf_set[i] | (ccf[i] & ~ccf_clr[i]);
      end
    end
  end

  // sequence status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sequence_complete_flag   <= 1'b0;
      trigger_overrun_flag <= 1'b0;
      result_overwrite_flag <= 1'b0;
    end else if (ce_in) begin
      sequence_complete_flag   <= seq_end |
               (sequence_complete_flag & ~((wr_ctl && wr_idx == IDX_STAT0 && w_byte[ST_SCF]) || start_sw ||
                        (res_rd && ctl2[C2_FAST_CLR])));
      trigger_overrun_flag <= (ctl2[C2_TRIG_EN] && !ctl2[C2_TRIG_LVL] && trig_rise &&
                state == ADCFS_RUN && !abort && !start_sw) |
               (trigger_overrun_flag & ~((wr_ctl && wr_idx == IDX_STAT0 && w_byte[ST_TRIGGER_OVERRUN_FLAG]) || abort ||
                          start_sw));
      result_overwrite_flag <= (conv_take && ccf[conv_cnt]) |
               (result_overwrite_flag & ~((wr_ctl && wr_idx == IDX_STAT0 && w_byte[ST_RESULT_OVERWRITE_FLAG]) || start_sw ||
                          trig_start));
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_conv_write;
    conv_take;
  endsequence

  sequence s_seq_finish;
    s_conv_write ##0 seq_last;
  endsequence

  seq_flag_set_a: assert property (s_seq_finish |=> sequence_complete_flag)
    else $error("sequence complete flag not set at sequence end");
  seq_flag_clr_a: assert property (start_sw |=> !sequence_complete_flag)
    else $error("start write did not clear sequence complete flag");
  trig_over_set_a: assert property (ce_in && ctl2[C2_TRIG_EN] && !ctl2[C2_TRIG_LVL] &&
    trig_rise && state == ADCFS_RUN && !abort && !start_sw |=> trigger_overrun_flag)
    else $error("trigger overrun not flagged");
  abort_clears_a: assert property (abort |=> !trigger_overrun_flag && conv_cnt == 3'h0 && !busy_out)
    else $error("abort did not clear overrun and counter");
  over_write_a: assert property (s_conv_write ##0 ccf[conv_cnt] |=> result_overwrite_flag)
    else $error("result overwrite not flagged");
  over_clr_a: assert property (ce_in && (start_sw || trig_start) && !conv_take |=> !result_overwrite_flag)
    else $error("new sequence did not clear overwrite flag");
  cnt_end_zero_a: assert property (s_seq_finish ##0 !ctl3[C3_FIFO] |=> conv_cnt == 3'h0)
    else $error("counter not zero after sequence end");
  cnt_wrap_a: assert property (s_conv_write ##0 (conv_cnt == 3'h7) |=> conv_cnt == 3'h0)
    else $error("counter failed to wrap");
  cnt_fifo_keep_a: assert property (s_seq_finish ##0 ctl3[C3_FIFO] |=>
    conv_cnt == $past(conv_cnt) + 3'h1)
    else $error("counter reset in fifo mode");
  stat_wr_cnt_a: assert property (wr_ctl && wr_idx == IDX_STAT0 && !conv_take && !trig_start |=>
    $stable(conv_cnt))
    else $error("status write changed counter");
  rjust_zero_a: assert property (res_rd && fmt.rjust |=> s_axi_rdata_out[31:10] == 22'h0)
    else $error("right justified result has high bits set");
  chan_single_a: assert property (ce_in && busy_out && !ctl5[C5_MULTI_CHANNEL_SELECT] && !start_sw &&
    !trig_start |=> channel_out == $past(ctl5[C5_CODE_LSB +: CNT_W]))
    else $error("single channel mode left the selected input");
  chan_step_a: assert property (s_conv_write ##0 ctl5[C5_MULTI_CHANNEL_SELECT] && !seq_last |=>
    channel_out == $past(channel_out) + 3'h1)
    else $error("multi channel mode did not step the input");

endmodule : adcfs_top

// File: core/adcfs_pkg.sv
// package: register map, field layout and types of the converter result/status block
package adcfs_pkg;

  localparam int RAW_W  = 10;  // raw converter code width
  localparam int NRES   = 8;   // result registers / analog inputs
  localparam int CNT_W  = 3;   // conversion counter width
  localparam int ADDR_W = 8;   // byte address bits decoded

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL2   = 6'h02;
  localparam logic [5:0] IDX_CTL3   = 6'h03;
  localparam logic [5:0] IDX_CTL4   = 6'h04;
  localparam logic [5:0] IDX_CTL5   = 6'h05;
  localparam logic [5:0] IDX_STAT0  = 6'h06;
  localparam logic [5:0] IDX_TEST0  = 6'h08;
  localparam logic [5:0] IDX_CCF    = 6'h0B;
  localparam logic [5:0] IDX_RES0   = 6'h10;

  // control_two fields
  localparam int C2_TRIG_EN  = 2;
  localparam int C2_TRIG_LVL = 3;
  localparam int C2_FAST_CLR = 6;
  // control_three fields
  localparam int C3_LEN_LSB  = 0;
  localparam int C3_FIFO     = 3;
  // control_four fields
  localparam int C4_LOW_RES  = 7;
  // conversion_start_control fields
  localparam int C5_CODE_LSB = 0;
  localparam int C5_MULTI_CHANNEL_SELECT     = 4;
  localparam int C5_SCAN     = 5;
  localparam int C5_SIGNED   = 6;
  localparam int C5_RJUST    = 7;
  // sequence_status fields
  localparam int ST_SCF      = 7;
  localparam int ST_TRIGGER_OVERRUN_FLAG    = 5;
  localparam int ST_RESULT_OVERWRITE_FLAG    = 4;

  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [7:0]  TEST_RST = 8'h00;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    ADCFS_IDLE = 2'b00,
    ADCFS_RUN  = 2'b01
  } adcfs_state_t;

  // result format selection
  typedef struct packed {
    logic low_res;
    logic rjust;
    logic signd;
  } adcfs_fmt_t;

  // one conversion delivered by the analog front end
  typedef struct packed {
    logic             done;
    logic [RAW_W-1:0] data;
  } adcfs_conv_t;

endpackage : adcfs_pkg

// File: verification/adcfs_frontend.sv
// partner model: analog front end answering each conversion of a running sequence
module adcfs_frontend
#(parameter int GAP = 4)
(
  input  wire logic                                    clk_in,   // block clock
  input  wire logic                                    rst_b_in, // reset, active low
  input  wire logic                                    busy_in,  // sequence running
  input  wire logic [adcfs_pkg::CNT_W-1:0]             chan_in,  // selected analog input
  input  wire logic [7:0][adcfs_pkg::RAW_W-1:0]        level_in, // code on each input
  output adcfs_pkg::adcfs_conv_t                       conv_out  // finished conversion
);
  import adcfs_pkg::*;
  logic [3:0] wait_cnt;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_cnt <= 4'h0;
      conv_out <= '0;
    end else begin
      conv_out.done <= 1'b0;
      // data toggles between conversions so a stale code is never read as valid
      conv_out.data <= ~conv_out.data;
      if (busy_in && wait_cnt == 4'(GAP - 1)) begin
        wait_cnt      <= 4'h0;
        conv_out.done <= 1'b1;
        conv_out.data <= level_in[chan_in];
      end else begin
        wait_cnt <= busy_in ? wait_cnt + 4'h1 : 4'h0;
      end
    end
  end
endmodule // adcfs_frontend

// File: verification/testbench.sv
// testbench: register-level checks of result format, status flags and counter
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import adcfs_pkg::*;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst_b = 1'b0, special = 1'b0, trig = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdat;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] chan, k;
  adcfs_conv_t conv;
  logic [7:0][RAW_W-1:0] level = {10'h3C3, 10'h155, 10'h2AA, 10'h000,
                                  10'h001, 10'h1FF, 10'h200, 10'h3FF};
  int miscompares = 0, n_tests = 0, cyc = 0;

  always #25 clk = ~clk;

  adcfs_top adcfs_top_i (.clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1),
    .special_mode_in(special), .ext_trig_in(trig), .conv_in(conv), .channel_out(chan),
    .busy_out(busy), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

  adcfs_frontend #(.GAP(4)) adcfs_frontend_i (.clk_in(clk), .rst_b_in(rst_b),
    .busy_in(busy), .chan_in(chan), .level_in(level), .conv_out(conv));

  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw_done, w_done, got;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    r = '0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (awready && !aw_done) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wready && !w_done) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
      if (bvalid) begin
        r = bresp;
        got = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ar_done, got;
    ar_done = 1'b0;
    got = 1'b0;
    d = '0;
    r = '0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arready && !ar_done) begin
        arvalid <= 1'b0;
        ar_done = 1'b1;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        got = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic wait_idle;
    repeat (3) @(posedge clk);
    while (busy) @(posedge clk);
  endtask

  task automatic pulse;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask

  function automatic logic [15:0] fmt_exp(input logic [9:0] r, input logic [2:0] f);
    logic [15:0] v;
    if (f[2]) v = f[1] ? {8'h00, r[9:2]} : {r[9:2], 8'h00};
    else v = f[1] ? {6'h00, r} : {r, 6'h00};
    // signed applies to left justified only: flip the top bit of the offset code
    if (!f[1]) v[15] = v[15] ^ f[0];
    return v;
  endfunction

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    wr(IDX_CTL3, 8'h01, resp);
    for (int c = 0; c < 8; c++) begin
      k = 3'(c);
      wr(IDX_CTL4, {k[2], 7'h00}, resp);
      wr(IDX_CTL5, {k[1], k[0], 3'b000, k}, resp);
      wait_idle;
      rd(IDX_STAT0, rdat, resp);
      chk("status", 32'h00000080, rdat);
      rd(IDX_RES0, rdat, resp);
      chk("result", {16'h0000, fmt_exp(level[c], k)}, rdat);
    end
    wr(IDX_CTL3, 8'h02, resp);
    wr(IDX_CTL4, 8'h00, resp);
    wr(IDX_CTL5, 8'h17, resp);
    wait_idle;
    rd(IDX_RES0, rdat, resp);
    chk("result0", {16'h0000, level[7], 6'h00}, rdat);
    rd(6'h11, rdat, resp);
    chk("result1", {16'h0000, level[0], 6'h00}, rdat);
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000080, rdat);
    wr(IDX_STAT0, 8'h87, resp);
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000000, rdat);
    wr(IDX_CTL2, 8'h40, resp);
    wr(IDX_CTL5, 8'h00, resp);
    wait_idle;
    rd(IDX_RES0, rdat, resp);
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000000, rdat);
    // scan: flag comes back after being cleared mid-run
    wr(IDX_CTL2, 8'h00, resp);
    wr(IDX_CTL5, 8'h20, resp);
    repeat (40) @(posedge clk);
    wr(IDX_STAT0, 8'h80, resp);
    repeat (40) @(posedge clk);
    wr(IDX_CTL3, 8'h09, resp);
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000090, rdat);
    wr(IDX_CTL2, 8'h04, resp);
    wr(IDX_CTL5, 8'h00, resp);
    wait_idle;
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000081, rdat);
    repeat (8) begin
      pulse;
      wait_idle;
    end
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000091, rdat);
    pulse;
    pulse;
    wait_idle;
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h000000B2, rdat);
    wr(IDX_STAT0, 8'h30, resp);
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000082, rdat);
    pulse;
    pulse;
    wait_idle;
    wr(IDX_CTL4, 8'h00, resp);
    rd(IDX_STAT0, rdat, resp);
    chk("status", 32'h00000090, rdat);
    // complete flags: a flag read arms the clear, the next result read clears its flag
    rd(IDX_CCF, rdat, resp);
    chk("ccf", 32'h000000FF, rdat);
    rd(6'h12, rdat, resp);
    rd(IDX_CCF, rdat, resp);
    chk("ccf", 32'h000000FB, rdat);
    special <= 1'b1;
    wr(IDX_TEST0, 8'hA5, resp);
    rd(IDX_TEST0, rdat, resp);
    chk("test", 32'h000000A5, rdat);
    special <= 1'b0;
    wr(IDX_TEST0, 8'h3C, resp);
    rd(IDX_TEST0, rdat, resp);
    chk("test", 32'h000000A5, rdat);
    wr(6'h01, 8'h00, resp);
    chk("bresp", {30'h0, RESP_ERR}, {30'h0, resp});
    rd(6'h01, rdat, resp);
    chk("rresp", {30'h0, RESP_ERR}, {30'h0, resp});
    tally_and_finish;
  end
endmodule // testbench
